// >>> shared/supply_drop_consts.vh
// constants for the supply-drop reset and reset-cause flag block
// Overview of operation
// - supply-drop reset active except in power-down mode; drop below threshold resets part and sets drop flag.
// - low-supply indication resets only after persisting beyond the drop filter time.
// - four level codes select 2.1V, 2.55V, 3.15V or 3.8V threshold.
// - any other level code resets after two to three clocks, sets fault flag.
// - reset from an invalid level code restores the level select power-on value.
// - genuine drop reset follows after two to three clocks, level select kept.
// - level select register powers up holding 01010101.
// - supply-drop reset is disabled while the part is in power-down mode.
// - drop flag, bit 2, set by hardware, cleared only by writing zero.
// - level fault flag, bit 1, set by hardware, cleared only by software.
// - reset flag bits 6 to 4 are unimplemented and read zero.
// - watchdog time-out in normal mode acts as a pin reset and sets timeout.
// - watchdog time-out in sleep or idle clears only PC and SP, sets timeout.
// - power-on clears timeout and power-down flags; watchdog resets set them per mode.
// - power-on zeroes PC, masks interrupts, clears watchdog, stops timers, pins input, SP top.
`ifndef SUPPLY_DROP_CONSTS_VH
`define SUPPLY_DROP_CONSTS_VH
`define ADDR_LEVEL_SELECT   12'h000
`define ADDR_RESET_CAUSE    12'h004
`define ADDR_CPU_STATUS     12'h008
`define ADDR_IRQ_STATUS     12'h00C
`define ADDR_IRQ_MASK       12'h010
`define LEVEL_POR           8'h55
`define LEVEL_2V10          8'h55
`define LEVEL_2V55          8'h33
`define LEVEL_3V15          8'h99
`define LEVEL_3V80          8'hAA
`define THR_2V10            2'h0
`define THR_2V55            2'h1
`define THR_3V15            2'h2
`define THR_3V80            2'h3
`define BIT_KEEP            7
`define BIT_PIN_FAULT       3
`define BIT_DROP            2
`define BIT_LEVEL_FAULT     1
`define BIT_WDT_FAULT       0
`define CAUSE_POR           8'h00
`define CAUSE_IMPL_MASK     8'h8F
`define BIT_TIMEOUT         0
`define BIT_POWER_DOWN      1
`define EV_DROP             0
`define EV_LEVEL_FAULT      1
`define EV_WDT_RUN          2
`define EV_WDT_LOW          3
`define MODE_NORMAL         2'h0
`define MODE_SLOW           2'h1
`define MODE_IDLE           2'h2
`define MODE_SLEEP          2'h3
`define CLK_PERIOD_NS       25
`define DROP_FILTER_NS      100
`define ISSUE_DELAY_CYC     2'h2
`endif

// >>> core/supply_drop_reset_and_flags.v
// supply-drop reset sequencer, reset-cause flags and watchdog reset handling with APB registers
`include "supply_drop_consts.vh"
`default_nettype none
module supply_drop_reset_and_flags #(
  parameter integer FILTER_NS = `DROP_FILTER_NS
) (
  input  wire        i_core_clk,
  input  wire        i_nrst,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire        o_pready,
  output wire        o_pslverr,
  input  wire        i_low_supply,
  input  wire [1:0]  i_cpu_mode,
  input  wire        i_power_down,
  input  wire        i_wdt_timeout,
  input  wire        i_pin_ctl_fault,
  input  wire        i_wdt_ctl_fault,
  output wire [1:0]  o_drop_threshold,
  output wire        o_sys_reset,
  output wire        o_pc_sp_clear,
  output wire        o_pc_clear,
  output wire        o_int_disable,
  output wire        o_wdt_tb_clear,
  output wire        o_timers_off,
  output wire        o_io_inputs,
  output wire        o_sp_top,
  output wire        o_idle_system_clock_keep,
  output wire        o_irq
);

  // least time rounds up to whole cycles
  localparam integer FILTER_CYC = (FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam [7:0]   FILTER_LIM = FILTER_CYC[7:0];
  localparam [1:0]   ISSUE_LIM  = `ISSUE_DELAY_CYC;

  localparam [1:0] ST_RUN   = 2'h0;
  localparam [1:0] ST_DROP  = 2'h1;
  localparam [1:0] ST_FAULT = 2'h2;

  // {valid, threshold} for a level code
  function [2:0] decode_level;
    input [7:0] code;
    begin
      case (code)
        `LEVEL_2V10: decode_level = {1'b1, `THR_2V10};
        `LEVEL_2V55: decode_level = {1'b1, `THR_2V55};
        `LEVEL_3V15: decode_level = {1'b1, `THR_3V15};
        `LEVEL_3V80: decode_level = {1'b1, `THR_3V80};
        default:     decode_level = 3'h0;
      endcase
    end
  endfunction

  reg  [7:0]  level_select_ff;
  reg  [7:0]  nxt_level_select;
  reg  [7:0]  reset_cause_ff;
  reg  [7:0]  nxt_reset_cause;
  reg  [1:0]  cpu_status_ff;
  reg  [1:0]  nxt_cpu_status;
  reg  [3:0]  irq_status_ff;
  reg  [3:0]  nxt_irq_status;
  reg  [3:0]  irq_mask_ff;
  reg  [1:0]  state_ff;
  reg  [1:0]  nxt_state;
  reg  [1:0]  delay_ff;
  reg  [1:0]  nxt_delay;
  reg  [7:0]  filter_ff;
  reg  [7:0]  nxt_filter;
  reg         low_meta_ff;
  reg         low_sync_ff;
  reg  [31:0] prdata_ff;
  reg         pready_ff;
  reg         pslverr_ff;
  reg  [1:0]  threshold_ff;
  reg         sys_reset_ff;
  reg         pc_sp_clear_ff;
  reg         por_ff;
  reg         irq_ff;
  reg         issue_drop;
  reg         issue_fault;
  reg  [31:0] rd_word;
  reg         rd_ok;

  wire [2:0] level_dec   = decode_level(level_select_ff);
  wire       level_valid = level_dec[2];
  wire       setup_ph    = i_psel & ~i_penable;
  wire       wr_en       = i_psel & i_penable & i_pwrite & pready_ff & ~pslverr_ff;
  wire       wr_level    = wr_en & (i_paddr == `ADDR_LEVEL_SELECT);
  wire       wr_cause    = wr_en & (i_paddr == `ADDR_RESET_CAUSE);
  wire       wr_irq_st   = wr_en & (i_paddr == `ADDR_IRQ_STATUS);
  wire       wr_irq_mask = wr_en & (i_paddr == `ADDR_IRQ_MASK);
  wire       wdt_low     = (i_cpu_mode == `MODE_IDLE) | (i_cpu_mode == `MODE_SLEEP);
  wire       wdt_run_ev  = i_wdt_timeout & ~wdt_low;
  wire       wdt_low_ev  = i_wdt_timeout & wdt_low;
  wire       drop_seen   = low_sync_ff & ~i_power_down;
  wire       drop_valid  = drop_seen & (filter_ff > FILTER_LIM);

  // two-stage synchroniser for the comparator output
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      low_meta_ff <= 1'b0;
      low_sync_ff <= 1'b0;
    end else begin
      low_meta_ff <= i_low_supply;
      low_sync_ff <= low_meta_ff;
    end
  end

  // persistence filter; short dips restart it and leave no trace
  always @* begin
    nxt_filter = 8'h00;
    if (drop_seen && state_ff == ST_RUN) begin
      if (filter_ff != 8'hFF) begin
        nxt_filter = filter_ff + 8'h01;
      end else begin
        nxt_filter = filter_ff;
      end
    end
  end

  // sequencer: invalid code outranks a drop since it may be what hides the threshold
  always @* begin
    nxt_state   = state_ff;
    nxt_delay   = delay_ff;
    issue_drop  = 1'b0;
    issue_fault = 1'b0;
    case (state_ff)
      ST_RUN: begin
        nxt_delay = 2'h0;
        if (!level_valid) begin
          nxt_state = ST_FAULT;
        end else if (drop_valid) begin
          nxt_state = ST_DROP;
        end
      end
      ST_DROP: begin
        nxt_delay = delay_ff + 2'h1;
        if (nxt_delay == ISSUE_LIM) begin
          issue_drop = 1'b1;
          nxt_state  = ST_RUN;
        end
      end
      ST_FAULT: begin
        nxt_delay = delay_ff + 2'h1;
        if (nxt_delay == ISSUE_LIM) begin
          issue_fault = 1'b1;
          nxt_state   = ST_RUN;
        end
      end
      default: begin
        nxt_state = ST_RUN;
        nxt_delay = 2'h0;
      end
    endcase
  end

  always @* begin
    nxt_level_select = level_select_ff;
    if (issue_fault) begin
      nxt_level_select = `LEVEL_POR;
    end else if (wr_level) begin
      nxt_level_select = i_pwdata[7:0];
    end
  end

  // flags clear only on a written zero; hardware set wins
  always @* begin
    nxt_reset_cause = reset_cause_ff;
    if (wr_cause) begin
      nxt_reset_cause = reset_cause_ff & i_pwdata[7:0];
      nxt_reset_cause[`BIT_KEEP] = i_pwdata[`BIT_KEEP];
    end
    if (issue_drop) begin
      nxt_reset_cause[`BIT_DROP] = 1'b1;
    end
    if (issue_fault) begin
      nxt_reset_cause[`BIT_LEVEL_FAULT] = 1'b1;
    end
    if (i_pin_ctl_fault) begin
      nxt_reset_cause[`BIT_PIN_FAULT] = 1'b1;
    end
    if (i_wdt_ctl_fault) begin
      nxt_reset_cause[`BIT_WDT_FAULT] = 1'b1;
    end
    nxt_reset_cause = nxt_reset_cause & `CAUSE_IMPL_MASK;
  end

  // drop resets leave both status flags alone
  always @* begin
    nxt_cpu_status = cpu_status_ff;
    if (wdt_run_ev) begin
      nxt_cpu_status[`BIT_TIMEOUT] = 1'b1;
    end
    if (wdt_low_ev) begin
      nxt_cpu_status[`BIT_TIMEOUT]    = 1'b1;
      nxt_cpu_status[`BIT_POWER_DOWN] = 1'b1;
    end
  end

  always @* begin
    nxt_irq_status = irq_status_ff;
    if (wr_irq_st) begin
      nxt_irq_status = irq_status_ff & ~i_pwdata[3:0];
    end
    if (issue_drop) begin
      nxt_irq_status[`EV_DROP] = 1'b1;
    end
    if (issue_fault) begin
      nxt_irq_status[`EV_LEVEL_FAULT] = 1'b1;
    end
    if (wdt_run_ev) begin
      nxt_irq_status[`EV_WDT_RUN] = 1'b1;
    end
    if (wdt_low_ev) begin
      nxt_irq_status[`EV_WDT_LOW] = 1'b1;
    end
  end

  always @* begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (i_paddr)
      `ADDR_LEVEL_SELECT: rd_word[7:0] = level_select_ff;
      `ADDR_RESET_CAUSE:  rd_word[7:0] = reset_cause_ff;
      `ADDR_CPU_STATUS:   rd_word[1:0] = cpu_status_ff;
      `ADDR_IRQ_STATUS:   rd_word[3:0] = irq_status_ff;
      `ADDR_IRQ_MASK:     rd_word[3:0] = irq_mask_ff;
      default:            rd_ok = 1'b0;
    endcase
  end

  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      level_select_ff <= `LEVEL_POR;
      reset_cause_ff  <= `CAUSE_POR;
      cpu_status_ff   <= 2'h0;
      irq_status_ff   <= 4'h0;
      irq_mask_ff     <= 4'h0;
      state_ff        <= ST_RUN;
      delay_ff        <= 2'h0;
      filter_ff       <= 8'h00;
      threshold_ff    <= `THR_2V10;
    end else begin
      level_select_ff <= nxt_level_select;
      reset_cause_ff  <= nxt_reset_cause;
      cpu_status_ff   <= nxt_cpu_status;
      irq_status_ff   <= nxt_irq_status;
      if (wr_irq_mask) begin
        irq_mask_ff <= i_pwdata[3:0];
      end
      state_ff  <= nxt_state;
      delay_ff  <= nxt_delay;
      filter_ff <= nxt_filter;
      // comparator keeps last good threshold while the code is invalid
      if (level_valid) begin
        threshold_ff <= level_dec[1:0];
      end
    end
  end

  // one-cycle access phase: ready rises in the cycle after setup
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setup_ph;
      pslverr_ff <= setup_ph & ~rd_ok;
      if (setup_ph && !i_pwrite) begin
        prdata_ff <= rd_word;
      end else if (setup_ph) begin
        prdata_ff <= 32'h0000_0000;
      end
    end
  end

  // reset pulses; register state here survives them, except level select on a fault reset; only power-on clears it
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      sys_reset_ff   <= 1'b0;
      pc_sp_clear_ff <= 1'b0;
      por_ff         <= 1'b1;
      irq_ff         <= 1'b0;
    end else begin
      sys_reset_ff   <= issue_drop | issue_fault | wdt_run_ev;
      pc_sp_clear_ff <= wdt_low_ev;
      por_ff         <= 1'b0;
      irq_ff         <= |(nxt_irq_status & irq_mask_ff);
    end
  end

  assign o_prdata                 = prdata_ff;
  assign o_pready                 = pready_ff;
  assign o_pslverr                = pslverr_ff;
  assign o_drop_threshold         = threshold_ff;
  assign o_sys_reset              = sys_reset_ff;
  assign o_pc_sp_clear            = pc_sp_clear_ff;
  assign o_pc_clear               = por_ff;
  assign o_int_disable            = por_ff;
  assign o_wdt_tb_clear           = por_ff;
  assign o_timers_off             = por_ff;
  assign o_io_inputs              = por_ff;
  assign o_sp_top                 = por_ff;
  assign o_idle_system_clock_keep = reset_cause_ff[`BIT_KEEP];
  assign o_irq                    = irq_ff;

endmodule
`default_nettype wire

// >>> verif/supply_monitor_model.sv
// comparator stand-in driving the low-supply indication
`default_nettype none
module supply_monitor_model (
  input  wire logic i_core_clk,
  output var logic  o_low_supply
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_low_supply = 1'b0;
  // dip of n clock cycles; supply back in range otherwise
  task automatic dip(input int n);
    @(posedge i_core_clk);
    o_low_supply <= 1'b1;
    repeat (n) @(posedge i_core_clk);
    o_low_supply <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> verif/supply_drop_reset_and_flags_monitor.sv
// port assertions for the supply-drop reset block
`include "supply_drop_consts.vh"
`default_nettype none
module supply_drop_reset_and_flags_monitor (
  input wire logic        i_core_clk,
  input wire logic        i_nrst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        i_wdt_timeout,
  input wire logic [1:0]  i_cpu_mode,
  input wire logic        i_power_down,
  input wire logic        o_sys_reset,
  input wire logic        o_pc_sp_clear,
  input wire logic        o_pc_clear,
  input wire logic        o_io_inputs,
  input wire logic        o_sp_top,
  input wire logic [1:0]  o_drop_threshold
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  property p_wdt_run;
    i_wdt_timeout && i_cpu_mode < 2'h2 |=> o_sys_reset && !o_pc_sp_clear;
  endproperty
  a_wdt_run: assert property (p_wdt_run) else $error("watchdog run reset missing");
  property p_wdt_low;
    i_wdt_timeout && i_cpu_mode >= 2'h2 |=> o_pc_sp_clear && !o_sys_reset;
  endproperty
  a_wdt_low: assert property (p_wdt_low) else $error("watchdog low-power clear wrong");
  property p_one_pulse;
    o_sys_reset |=> !o_sys_reset;
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("reset pulse too long");
  property p_bad_code;
    i_psel && i_penable && o_pready && i_pwrite && i_paddr == `ADDR_LEVEL_SELECT &&
    !(i_pwdata[7:0] inside {`LEVEL_2V10, `LEVEL_2V55, `LEVEL_3V15, `LEVEL_3V80}) |-> ##[1:4] o_sys_reset;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("invalid code gave no reset");
  property p_pd_off;
    (i_power_down && !i_wdt_timeout)[*8] |-> !o_sys_reset;
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("reset in power-down");
  property p_por_outs;
    $rose(i_nrst) |-> o_pc_clear && o_io_inputs && o_sp_top ##1 !o_pc_clear && !o_io_inputs && !o_sp_top;
  endproperty
  a_por_outs: assert property (p_por_outs) else $error("power-on outputs wrong");
  property p_por_thr;
    $rose(i_nrst) |-> o_drop_threshold == `THR_2V10;
  endproperty
  a_por_thr: assert property (p_por_thr) else $error("power-on threshold wrong");
  property p_unimpl;
    o_pready && !i_pwrite && i_paddr == `ADDR_RESET_CAUSE |-> o_prdata[6:4] == 3'h0;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unused cause bits set");
endmodule
bind supply_drop_reset_and_flags supply_drop_reset_and_flags_monitor i_supply_drop_reset_and_flags_monitor (.*);
`default_nettype wire

// >>> verif/supply_drop_reset_and_flags_tb_top.sv
// self-checking bench for the supply-drop reset and cause flags
`include "supply_drop_consts.vh"
`default_nettype none
module supply_drop_reset_and_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_core_clk = 0, i_nrst = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, e, s, p;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0000_0000, o_prdata, r;
  logic        o_pready, o_pslverr, i_low_supply, i_power_down = 0, i_wdt_timeout = 0, o_irq;
  logic        i_pin_ctl_fault = 0, i_wdt_ctl_fault = 0, o_sys_reset, o_pc_sp_clear, o_pc_clear;
  logic        o_int_disable, o_wdt_tb_clear, o_timers_off, o_io_inputs, o_sp_top, o_idle_system_clock_keep;
  logic [1:0]  i_cpu_mode = 2'h0, o_drop_threshold;
  logic [7:0]  codes [4] = '{8'h55, 8'h33, 8'h99, 8'hAA};
  int          error_cnt = 0, total_checks = 0;
  supply_drop_reset_and_flags #(.FILTER_NS(100)) i_supply_drop_reset_and_flags (.*);
  supply_monitor_model i_supply_monitor_model (.i_core_clk(i_core_clk), .o_low_supply(i_low_supply));
  initial forever #12.5 i_core_clk = ~i_core_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    // no local limit: only the watchdog ends a wait
    do begin
      @(posedge i_core_clk);
    end while (o_pready !== 1'b1);
    r = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  // counts cycles and notes either reset pulse, sampled once settled
  task automatic pulse_wait(input int lim);
    s = 1'b0;
    p = 1'b0;
    repeat (lim) begin
      @(posedge i_core_clk);
      #1 s = s | o_sys_reset;
      p = p | o_pc_sp_clear;
    end
  endtask
  task automatic dip_and_wait(input int n, input int lim);
    fork
      i_supply_monitor_model.dip(n);
      pulse_wait(lim);
    join
  endtask
  task automatic t_codes;
    rd(`ADDR_LEVEL_SELECT);
    chk(r, 32'h0000_0055);
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_LEVEL_SELECT, {24'h00_0000, codes[i]});
      pulse_wait(3);
      chk(o_drop_threshold, i);
    end
  endtask
  task automatic t_drop;
    wr(`ADDR_LEVEL_SELECT, 32'h0000_0033);
    dip_and_wait(2, 20);
    chk(s, 1'b0);
    dip_and_wait(12, 30);
    chk(s, 1'b1);
    rd(`ADDR_RESET_CAUSE);
    chk(r, 32'h0000_0004);
    rd(`ADDR_LEVEL_SELECT);
    chk(r, 32'h0000_0033);
    rd(`ADDR_CPU_STATUS);
    chk(r, 32'h0000_0000);
    chk(o_irq, 1'b0);
    wr(`ADDR_IRQ_MASK, 32'h0000_0001);
    pulse_wait(2);
    chk(o_irq, 1'b1);
    wr(`ADDR_IRQ_STATUS, 32'h0000_0001);
    pulse_wait(2);
    chk(o_irq, 1'b0);
    wr(`ADDR_RESET_CAUSE, 32'h0000_0004);
    rd(`ADDR_RESET_CAUSE);
    chk(r, 32'h0000_0004);
    wr(`ADDR_RESET_CAUSE, 32'h0000_0000);
    rd(`ADDR_RESET_CAUSE);
    chk(r, 32'h0000_0000);
  endtask
  task automatic t_pd_and_fault;
    i_power_down <= 1'b1;
    dip_and_wait(12, 30);
    chk(s, 1'b0);
    @(posedge i_core_clk);
    i_power_down <= 1'b0;
    wr(`ADDR_LEVEL_SELECT, 32'h0000_0012);
    pulse_wait(6);
    chk(s, 1'b1);
    rd(`ADDR_LEVEL_SELECT);
    chk(r, 32'h0000_0055);
    rd(`ADDR_RESET_CAUSE);
    chk(r, 32'h0000_0002);
  endtask
  // flags stay set, so status only grows across the mode sweep
  task automatic t_wdt;
    for (int m = 0; m < 4; m++) begin
      i_cpu_mode <= m[1:0];
      i_wdt_timeout <= 1'b1;
      // watch from the edge that takes the pulse; the one-cycle reset follows it
      fork
        begin
          @(posedge i_core_clk);
          i_wdt_timeout <= 1'b0;
        end
        pulse_wait(4);
      join
      chk({s, p}, (m < 2) ? 2'b10 : 2'b01);
      rd(`ADDR_CPU_STATUS);
      chk(r, (m < 2) ? 32'h0000_0001 : 32'h0000_0003);
    end
  endtask
  task automatic t_cause;
    i_pin_ctl_fault <= 1'b1;
    i_wdt_ctl_fault <= 1'b1;
    @(posedge i_core_clk);
    i_pin_ctl_fault <= 1'b0;
    i_wdt_ctl_fault <= 1'b0;
    wr(`ADDR_RESET_CAUSE, 32'hFFFF_FFFF);
    pulse_wait(6);
    chk(s, 1'b0);
    rd(`ADDR_RESET_CAUSE);
    chk(r, 32'h0000_008B);
    chk(o_idle_system_clock_keep, 1'b1);
    rd(12'h0FC);
    chk(r, 32'h0000_0000);
    chk(e, 1'b1);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200us;
    error_cnt++;
    conclude;
  end
  initial begin
    repeat (11) @(posedge i_core_clk);
    #1 chk({o_pc_clear, o_io_inputs, o_sp_top, o_int_disable, o_wdt_tb_clear, o_timers_off}, 6'h3F);
    @(posedge i_core_clk);
    i_nrst <= 1'b1;
    pulse_wait(2);
    chk({o_pc_clear, o_io_inputs, o_sp_top, o_int_disable, o_wdt_tb_clear, o_timers_off}, 6'h00);
    rd(`ADDR_CPU_STATUS);
    chk(r, 32'h0000_0000);
    t_codes;
    t_drop;
    t_pd_and_fault;
    t_wdt;
    t_cause;
    conclude;
  end
endmodule
`default_nettype wire
